/* rtl/usd_pkg.sv */
// Constants, register map and carrier types for the shadow data port block
package usd_pkg;

    // Data path and FIFO sizing
    localparam int unsigned USD_DATA_W     = 8;
    localparam int unsigned USD_FIFO_DEPTH = 16;

    // Shadow data window: sixteen word-spaced aliases
    localparam logic [31:0] USD_SHADOW_7_ADDR  = 32'h5000_114C;
    localparam logic [31:0] USD_SHADOW_8_ADDR  = 32'h5000_1150;
    localparam logic [31:0] USD_SHADOW_7_IDX   = 32'h0000_0007;
    localparam logic [31:0] USD_SHADOW_COUNT   = 32'h0000_0010;
    localparam logic [31:0] USD_WORD_BYTES     = 32'h0000_0004;
    localparam logic [31:0] USD_SHADOW_BASE    = USD_SHADOW_7_ADDR
                                                 - USD_SHADOW_7_IDX * USD_WORD_BYTES;
    localparam logic [31:0] USD_SHADOW_LAST    = USD_SHADOW_BASE
                                                 + (USD_SHADOW_COUNT - 32'h1) * USD_WORD_BYTES;

    // Control, status and interrupt registers
    localparam logic [31:0] USD_CTRL_ADDR      = 32'h5000_1180;
    localparam logic [31:0] USD_STATUS_ADDR    = 32'h5000_1184;
    localparam logic [31:0] USD_IRQ_STAT_ADDR  = 32'h5000_1188;
    localparam logic [31:0] USD_IRQ_MASK_ADDR  = 32'h5000_118C;

    // Control fields
    localparam int unsigned USD_CTRL_FIFO_EN   = 0;
    localparam int unsigned USD_CTRL_IR_MODE   = 1;

    // Status fields, data ready and holding empty in line status positions
    localparam int unsigned USD_ST_DATA_READY  = 0;
    localparam int unsigned USD_ST_OVERRUN     = 1;
    localparam int unsigned USD_ST_HOLD_EMPTY  = 5;

    // Interrupt event bits
    localparam int unsigned USD_IRQ_W          = 3;
    localparam int unsigned USD_EV_RX          = 0;
    localparam int unsigned USD_EV_HOLD_EMPTY  = 1;
    localparam int unsigned USD_EV_OVERRUN     = 2;

    // AXI responses
    localparam logic [1:0]  USD_RESP_OKAY      = 2'h0;
    localparam logic [1:0]  USD_RESP_SLVERR    = 2'h2;

    // One character with its strobe
    typedef struct packed {
        logic                  valid;
        logic [USD_DATA_W-1:0] data;
    } usd_byte_t;

    // State of the top module, apart from its two FIFO instances
    typedef struct packed {
        logic                  aw_full;
        logic [31:0]           aw_addr;
        logic                  w_full;
        logic [31:0]           w_data;
        logic [3:0]            w_strb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [1:0]            rresp;
        logic [31:0]           rdata;
        logic                  fifo_en;
        logic                  ir_mode;
        logic [USD_DATA_W-1:0] rx_hold;
        logic                  rx_hold_valid;
        logic [USD_DATA_W-1:0] tx_hold;
        logic                  tx_hold_valid;
        logic                  overrun;
        logic [USD_IRQ_W-1:0]  irq_stat;
        logic [USD_IRQ_W-1:0]  irq_mask;
        logic                  empty_prev;
    } usd_state_t;

    localparam usd_state_t USD_STATE_RESET = '{empty_prev: 1'b1, default: '0};

endpackage

/* rtl/usd_byte_fifo.sv */
// Flip-flop character FIFO used for both receive and transmit queues
`timescale 1ns/1ps
`default_nettype none

module usd_byte_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // Control
    input  wire logic             flush,
    // Fill side
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] push_data,
    // Drain side
    input  wire logic             pop,
    output logic      [WIDTH-1:0] head,
    output logic                  empty,
    output logic                  full
);
    localparam int unsigned PTR_W = $clog2(DEPTH);
    localparam int unsigned CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            wr_ptr;
        logic [PTR_W-1:0]            rd_ptr;
        logic [CNT_W-1:0]            count;
    } usd_fifo_state_t;

    usd_fifo_state_t q;
    usd_fifo_state_t d;
    logic            do_push;
    logic            do_pop;

    assign empty = (q.count == '0);
    assign full  = (q.count == CNT_FULL);
    assign head  = q.mem[q.rd_ptr];

    always_comb begin
        d       = q;
        do_pop  = pop && !empty;
        // A full queue still takes a push when a pop frees a slot that cycle
        do_push = push && (!full || do_pop);
        if (do_push) begin
            d.mem[q.wr_ptr] = push_data;
            d.wr_ptr        = q.wr_ptr + PTR_ONE;
        end
        if (do_pop) begin
            d.rd_ptr = q.rd_ptr + PTR_ONE;
        end
        if (do_push && !do_pop) begin
            d.count = q.count + CNT_ONE;
        end else if (do_pop && !do_push) begin
            d.count = q.count - CNT_ONE;
        end
        if (flush) begin
            d.wr_ptr = '0;
            d.rd_ptr = '0;
            d.count  = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule // usd_byte_fifo

`default_nettype wire

/* rtl/usd_shadow_port.sv */
// Shadow data port: AXI4-Lite aliases of receive buffer and transmit holding
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Sixteen consecutive words alias receive buffer and transmit holding for bursts.
// - Low byte read returns serial byte, or infrared byte in infrared mode.
// - FIFOs off: a new character overwrites the unread byte and flags overrun.
// - FIFOs on: a shadow read returns the receive FIFO head, or zero when the FIFO is empty.
// - Receive FIFO full: keep contents, drop newcomer, flag overrun.
// - Low byte write queues a character for serial or infrared output.
// - FIFOs off: one write clears holding empty.
// - FIFOs off: further writes before holding empty replace the pending byte.
// - FIFOs on: accept writes up to the sixteen-deep transmit FIFO.
// - Transmit write while FIFO full is dropped, contents unchanged.
module usd_shadow_port
    import usd_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // AXI4-Lite write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Received characters from the serial and infrared receivers
    input  wire usd_byte_t   rx_serial,
    input  wire usd_byte_t   rx_infrared,
    // Characters to the serial and infrared transmitters
    output usd_byte_t        tx_serial,
    input  wire logic        tx_serial_ready,
    output usd_byte_t        tx_infrared,
    input  wire logic        tx_infrared_ready,
    // Interrupt
    output logic             irq
);

    usd_state_t                q;
    usd_state_t                d;

    // Datapath signals
    usd_byte_t                 rx_in;
    usd_byte_t                 tx_out;
    logic                      tx_ready;
    logic                      tx_take;
    logic                      rx_data_ready_flag;
    logic                      tx_holding_empty;
    logic [USD_DATA_W-1:0]     receive_buffer;

    // FIFO hookup
    logic                      fifo_flush;
    logic                      rx_push;
    logic                      rx_pop;
    logic [USD_DATA_W-1:0]     rx_head;
    logic                      rx_empty;
    logic                      rx_full;
    logic                      tx_push;
    logic                      tx_pop;
    logic [USD_DATA_W-1:0]     tx_head;
    logic                      tx_empty;
    logic                      tx_full;

    // Bus decode
    logic                      do_write;
    logic                      ar_take;
    logic                      rd_shadow;
    logic                      wr_shadow;
    logic                      ev_rx;
    logic                      ev_overrun;
    logic                      ev_empty;
    logic [USD_IRQ_W-1:0]      irq_clear;

    function automatic logic shadow_hit(input logic [31:0] addr);
        shadow_hit = (addr >= USD_SHADOW_BASE) && (addr <= USD_SHADOW_LAST)
                     && (addr[1:0] == 2'h0);
    endfunction

    // Bus handshakes; one write and one read in flight
    assign s_axi_awready = !q.aw_full && !q.bvalid;
    assign s_axi_wready  = !q.w_full && !q.bvalid;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rresp   = q.rresp;
    assign s_axi_rdata   = q.rdata;
    assign irq           = |(q.irq_stat & q.irq_mask);

    // Receiver select by line mode
    assign rx_in = q.ir_mode ? rx_infrared : rx_serial;

    // Transmit source: FIFO head or single holding byte
    always_comb begin
        if (q.fifo_en) begin
            tx_out.valid = !tx_empty;
            tx_out.data  = tx_head;
        end else begin
            tx_out.valid = q.tx_hold_valid;
            tx_out.data  = q.tx_hold;
        end
    end

    // Infrared output polarity belongs to the modulator, this carries the byte only
    assign tx_serial   = q.ir_mode ? usd_byte_t'('0) : tx_out;
    assign tx_infrared = q.ir_mode ? tx_out : usd_byte_t'('0);
    assign tx_ready    = q.ir_mode ? tx_infrared_ready : tx_serial_ready;
    assign tx_take     = tx_out.valid && tx_ready;

    assign rx_data_ready_flag = q.fifo_en ? !rx_empty : q.rx_hold_valid;
    assign tx_holding_empty   = q.fifo_en ? tx_empty : !q.tx_hold_valid;
    assign receive_buffer     = q.fifo_en ? rx_head : q.rx_hold;

    assign do_write  = q.aw_full && q.w_full && !q.bvalid;
    assign ar_take   = s_axi_arvalid && s_axi_arready;
    assign rd_shadow = ar_take && shadow_hit(s_axi_araddr);
    assign wr_shadow = do_write && shadow_hit(q.aw_addr) && q.w_strb[0];

    // Shadow read consumes a character only when one is ready
    assign rx_pop  = q.fifo_en && rd_shadow && !rx_empty;
    assign rx_push = q.fifo_en && rx_in.valid;
    assign tx_push = q.fifo_en && wr_shadow && !tx_full;
    assign tx_pop  = q.fifo_en && tx_take;

    // Overrun in either mode
    always_comb begin
        if (q.fifo_en) begin
            ev_overrun = rx_in.valid && rx_full && !rx_pop;
        end else begin
            ev_overrun = rx_in.valid && q.rx_hold_valid && !rd_shadow;
        end
    end

    assign ev_rx    = rx_in.valid && !ev_overrun;
    assign ev_empty = tx_holding_empty && !q.empty_prev;

    always_comb begin
        d          = q;
        fifo_flush = 1'b0;
        irq_clear  = '0;

        // Address and data channels taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_full = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_full = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end

        // Receive and transmit holding bytes, FIFOs off
        if (!q.fifo_en) begin
            if (rd_shadow) begin
                d.rx_hold_valid = 1'b0;
            end
            if (rx_in.valid) begin
                d.rx_hold       = rx_in.data;
                d.rx_hold_valid = 1'b1;
            end
            if (tx_take) begin
                d.tx_hold_valid = 1'b0;
            end
        end

        // Register writes
        if (do_write) begin
            d.aw_full = 1'b0;
            d.w_full  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = USD_RESP_OKAY;
            if (shadow_hit(q.aw_addr)) begin
                if (q.w_strb[0] && !q.fifo_en) begin
                    // Overwrite pending byte; a same-cycle drain loses to it
                    d.tx_hold       = q.w_data[USD_DATA_W-1:0];
                    d.tx_hold_valid = 1'b1;
                end
            end else if (q.aw_addr == USD_CTRL_ADDR) begin
                if (q.w_strb[0]) begin
                    d.fifo_en = q.w_data[USD_CTRL_FIFO_EN];
                    d.ir_mode = q.w_data[USD_CTRL_IR_MODE];
                    // A FIFO enable change empties every queue so no stale byte survives; an infrared mode change alone does not
                    if (q.w_data[USD_CTRL_FIFO_EN] != q.fifo_en) begin
                        fifo_flush      = 1'b1;
                        d.rx_hold_valid = 1'b0;
                        d.tx_hold_valid = 1'b0;
                    end
                end
            end else if (q.aw_addr == USD_STATUS_ADDR) begin
                d.bresp = USD_RESP_OKAY;
            end else if (q.aw_addr == USD_IRQ_STAT_ADDR) begin
                if (q.w_strb[0]) begin
                    irq_clear = q.w_data[USD_IRQ_W-1:0];
                end
            end else if (q.aw_addr == USD_IRQ_MASK_ADDR) begin
                if (q.w_strb[0]) begin
                    d.irq_mask = q.w_data[USD_IRQ_W-1:0];
                end
            end else begin
                d.bresp = USD_RESP_SLVERR;
            end
        end

        // Register reads, answered one cycle after the address is taken
        if (ar_take) begin
            d.rvalid = 1'b1;
            d.rresp  = USD_RESP_OKAY;
            d.rdata  = '0;
            if (shadow_hit(s_axi_araddr)) begin
                if (rx_data_ready_flag) begin
                    d.rdata[USD_DATA_W-1:0] = receive_buffer;
                end
            end else if (s_axi_araddr == USD_CTRL_ADDR) begin
                d.rdata[USD_CTRL_FIFO_EN] = q.fifo_en;
                d.rdata[USD_CTRL_IR_MODE] = q.ir_mode;
            end else if (s_axi_araddr == USD_STATUS_ADDR) begin
                d.rdata[USD_ST_DATA_READY] = rx_data_ready_flag;
                d.rdata[USD_ST_OVERRUN]    = q.overrun;
                d.rdata[USD_ST_HOLD_EMPTY] = tx_holding_empty;
                d.overrun                  = 1'b0;
            end else if (s_axi_araddr == USD_IRQ_STAT_ADDR) begin
                d.rdata[USD_IRQ_W-1:0] = q.irq_stat;
            end else if (s_axi_araddr == USD_IRQ_MASK_ADDR) begin
                d.rdata[USD_IRQ_W-1:0] = q.irq_mask;
            end else begin
                d.rresp = USD_RESP_SLVERR;
            end
        end

        // Sticky flags: a new event beats a same-cycle clear
        if (ev_overrun) begin
            d.overrun = 1'b1;
        end
        d.irq_stat = q.irq_stat & ~irq_clear;
        if (ev_rx) begin
            d.irq_stat[USD_EV_RX] = 1'b1;
        end
        if (ev_empty) begin
            d.irq_stat[USD_EV_HOLD_EMPTY] = 1'b1;
        end
        if (ev_overrun) begin
            d.irq_stat[USD_EV_OVERRUN] = 1'b1;
        end
        d.empty_prev = tx_holding_empty;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= USD_STATE_RESET;
        end else begin
            q <= d;
        end
    end

    // Receive queue
    usd_byte_fifo #(
        .WIDTH (USD_DATA_W),
        .DEPTH (USD_FIFO_DEPTH)
    ) u_rx_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .flush     (fifo_flush),
        .push      (rx_push),
        .push_data (rx_in.data),
        .pop       (rx_pop),
        .head      (rx_head),
        .empty     (rx_empty),
        .full      (rx_full)
    );

    // Transmit queue
    usd_byte_fifo #(
        .WIDTH (USD_DATA_W),
        .DEPTH (USD_FIFO_DEPTH)
    ) u_tx_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .flush     (fifo_flush),
        .push      (tx_push),
        .push_data (q.w_data[USD_DATA_W-1:0]),
        .pop       (tx_pop),
        .head      (tx_head),
        .empty     (tx_empty),
        .full      (tx_full)
    );

endmodule // usd_shadow_port

`default_nettype wire

/* verif/usd_shadow_port_chk.sv */
// Bus and transmit-side checker for the shadow data port
`timescale 1ns/1ps
`default_nettype none

module usd_chk
    import usd_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Register bus
    input  wire logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Transmit side
    input  wire usd_byte_t   tx_serial,
    input  wire logic        tx_serial_ready,
    input  wire usd_byte_t   tx_infrared,
    input  wire logic        tx_infrared_ready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    wr_lat_a:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> ##1 s_axi_bvalid) else $error("write answer not two cycles after taking");
    rd_lat_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
            else $error("read answer late");
    wr_block_a:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
            else $error("write taken while answer pending");
    rd_block_a:
        assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    b_once_a:
        assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
            else $error("write answer repeated");
    r_once_a:
        assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
            else $error("read answer repeated");
    upper_zero_a:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
            else $error("upper read bits not zero");
    tx_route_a:
        assert property (!(tx_serial.valid && tx_infrared.valid))
            else $error("both transmit routes active");

    // Main scenarios reached
    cov_wr: cover property (s_axi_bvalid && s_axi_bready);
    cov_rd: cover property (s_axi_rvalid && s_axi_rready);
    cov_txs: cover property (tx_serial.valid && tx_serial_ready);
    cov_txi: cover property (tx_infrared.valid && tx_infrared_ready);
endmodule // usd_chk

bind usd_shadow_port usd_chk u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .tx_serial(tx_serial), .tx_serial_ready(tx_serial_ready),
    .tx_infrared(tx_infrared), .tx_infrared_ready(tx_infrared_ready)
);

`default_nettype wire

/* verif/usd_link_model.sv */
// Remote serial and infrared transceiver model
`timescale 1ns/1ps
`default_nettype none

module usd_link_model
    import usd_pkg::*;
(
    // Clock
    input  wire logic      sys_clk,
    // Received characters into the port
    output usd_byte_t      rx_serial,
    output usd_byte_t      rx_infrared,
    // Characters out of the port
    input  wire usd_byte_t tx_serial,
    output logic           tx_serial_ready,
    input  wire usd_byte_t tx_infrared,
    output logic           tx_infrared_ready
);
    logic       stall = 1'b0;
    logic       slow = 1'b0;
    logic [8:0] got[$];

    initial begin
        rx_serial = '0;
        rx_infrared = '0;
        tx_serial_ready = 1'b0;
        tx_infrared_ready = 1'b0;
    end

    // One-cycle strobe per character
    task automatic send(input logic ir, input logic [7:0] d);
        @(posedge sys_clk);
        if (ir) begin
            rx_infrared <= '{valid: 1'b1, data: d};
        end else begin
            rx_serial <= '{valid: 1'b1, data: d};
        end
        @(posedge sys_clk);
        // Idle data inverted so a stale copy is never mistaken for fresh
        rx_serial <= '{valid: 1'b0, data: ~rx_serial.data};
        rx_infrared <= '{valid: 1'b0, data: ~rx_infrared.data};
    endtask

    // Slow mode takes at most every other cycle
    always @(posedge sys_clk) begin
        if (tx_serial.valid && tx_serial_ready) got.push_back({1'b0, tx_serial.data});
        if (tx_infrared.valid && tx_infrared_ready) got.push_back({1'b1, tx_infrared.data});
        tx_serial_ready <= !stall && !(slow && tx_serial_ready);
        tx_infrared_ready <= !stall && !(slow && tx_infrared_ready);
    end
endmodule // usd_link_model

`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the shadow data port
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import usd_pkg::*;
;
    localparam logic [31:0] CT = USD_CTRL_ADDR;
    localparam logic [31:0] ST = USD_STATUS_ADDR;
    localparam logic [31:0] IS = USD_IRQ_STAT_ADDR;
    localparam logic [31:0] IM = USD_IRQ_MASK_ADDR;
    localparam logic [31:0] SB = USD_SHADOW_BASE;

    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [31:0] awaddr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] araddr = '0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    // Held high: answers are taken at the edge they show, and no double drive
    logic        bready = 1'b1;
    logic        arvalid = 1'b0;
    logic        rready = 1'b1;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic        irq;
    logic        txs_rdy;
    logic        txi_rdy;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    usd_byte_t   rxs;
    usd_byte_t   rxi;
    usd_byte_t   txs;
    usd_byte_t   txi;
    int          miscompares = 0;
    int          check_count = 0;

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    usd_shadow_port uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_serial(rxs), .rx_infrared(rxi),
        .tx_serial(txs), .tx_serial_ready(txs_rdy), .tx_infrared(txi),
        .tx_infrared_ready(txi_rdy), .irq(irq)
    );

    usd_link_model lnk (
        .sys_clk(sys_clk), .rx_serial(rxs), .rx_infrared(rxi), .tx_serial(txs),
        .tx_serial_ready(txs_rdy), .tx_infrared(txi), .tx_infrared_ready(txi_rdy)
    );

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic tmo(input int n);
        if (n >= 100) begin
            miscompares++;
            $display("BAD handshake expected answer seen none");
            print_verdict();
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready || wvalid && !wready) && ++n < 100);
        do @(posedge sys_clk); while (!bvalid && ++n < 100);
        r = bresp;
        tmo(n);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge sys_clk); while (!arready && ++n < 100);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (!rvalid && ++n < 100);
        d = rdata;
        r = rresp;
        tmo(n);
    endtask

    task automatic wc(input logic [31:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk("write resp", 32'h0, {30'h0, r});
    endtask

    task automatic rc(input logic [31:0] a, input logic [31:0] e, input string n);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(n, e, d);
        chk("read resp", 32'h0, {30'h0, r});
    endtask

    task automatic waitgot(input int k);
        int n;
        n = 0;
        do @(posedge sys_clk); while (lnk.got.size() < k && ++n < 100);
        tmo(n);
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rc(CT, 32'h0, "ctrl reset");
        rc(ST, 32'h20, "status reset");
        rc(USD_SHADOW_7_ADDR, 32'h0, "no data");
        wr(32'h5000_1190, 32'h1, r);
        chk("unmapped wr", {30'h0, USD_RESP_SLVERR}, {30'h0, r});
        rd(32'h5000_1190, d, r);
        chk("unmapped rd", {30'h0, USD_RESP_SLVERR}, {30'h0, r});
        // Masked event stays quiet until unmasked
        lnk.send(1'b0, 8'hA5);
        chk("irq masked", 32'h0, {31'h0, irq});
        wc(IM, 32'h5);
        chk("irq on", 32'h1, {31'h0, irq});
        lnk.send(1'b0, 8'h5A);
        rc(IS, 32'h5, "irq stat");
        rc(ST, 32'h23, "overrun");
        rc(USD_SHADOW_7_ADDR, 32'h5A, "rx last");
        wc(IS, 32'h5);
        chk("irq off", 32'h0, {31'h0, irq});
        // Infrared route, single holding byte
        wc(CT, 32'h2);
        lnk.send(1'b1, 8'h3C);
        rc(USD_SHADOW_8_ADDR, 32'h3C, "rx ir");
        lnk.stall <= 1'b1;
        wc(USD_SHADOW_8_ADDR, 32'hABCD_EF99);
        rc(ST, 32'h0, "hold full");
        wc(SB, 32'h77);
        lnk.stall <= 1'b0;
        waitgot(1);
        chk("tx ir", 32'h177, {23'h0, lnk.got.pop_front()});
        rc(ST, 32'h20, "hold empty");
        // Receive queue through every alias
        wc(CT, 32'h1);
        for (int i = 0; i < 17; i++) lnk.send(1'b0, 8'h10 + 8'(i));
        rc(ST, 32'h23, "fifo overrun");
        for (int i = 0; i < 16; i++) rc(SB + 32'(4 * i), 32'h10 + 32'(i), "fifo head");
        rc(ST, 32'h20, "fifo drained");
        // Transmit queue filled past depth with the far side stalled
        lnk.stall <= 1'b1;
        for (int i = 0; i < 17; i++) wc(SB + 32'(4 * (i % 16)), 32'h80 + 32'(i));
        lnk.slow <= 1'b1;
        lnk.stall <= 1'b0;
        waitgot(16);
        repeat (4) @(posedge sys_clk);
        chk("tx count", 32'd16, 32'(lnk.got.size()));
        for (int i = 0; i < 16; i++) chk("tx fifo", 32'h80 + 32'(i), {23'h0, lnk.got[i]});
        print_verdict();
    end
endmodule // tb_top

`default_nettype wire
